/* File: rtl/socket_adapter_pkg.sv */
// Purpose: shared constants and carriers for the socket adapter register bank
// Assumes: 8-bit register file reached through an index port and a data port
// Notes:   every offset and field position, and the register reset values, live here

package socket_adapter_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int REG_W       = 8;
  localparam int NUM_SOCKETS = 2;
  localparam int CSC_W       = 4;

  // ----------------------------------------------------------------
  // index port fields
  // ----------------------------------------------------------------
  localparam int IDX_DEVICE_BIT = 7;
  localparam int IDX_SOCKET_BIT = 6;
  localparam int IDX_REG_LO     = 0;
  localparam int IDX_REG_W      = 6;
  localparam logic [7:0] INDEX_RESET = 8'h00;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [5:0] REG_CHIP_REVISION_ID      = 6'h00;
  localparam logic [5:0] REG_SOCKET_IF_STATUS      = 6'h01;
  localparam logic [5:0] REG_SOCKET_POWER_CONTROL  = 6'h02;
  localparam logic [5:0] REG_INTERRUPT_GEN_CONTROL = 6'h03;
  localparam logic [5:0] REG_CARD_STATUS_CHANGE    = 6'h04;
  localparam logic [5:0] REG_CHANGE_IRQ_CONFIG     = 6'h05;
  localparam logic [5:0] REG_WINDOW_MAP_ENABLE     = 6'h06;

  // ----------------------------------------------------------------
  // reset values and fixed answers
  // ----------------------------------------------------------------
  localparam logic [7:0] SOCKET_REG_RESET = 8'h00;
  localparam logic [3:0] CSC_RESET        = 4'h0;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  // ----------------------------------------------------------------
  // interface status bits
  // ----------------------------------------------------------------
  localparam int ST_VPP_VALID = 7;
  localparam int ST_POWER_ON  = 6;
  localparam int ST_READY     = 5;
  localparam int ST_WP        = 4;
  localparam int ST_DETECT_B  = 3;
  localparam int ST_DETECT_A  = 2;
  localparam int ST_BATT_B    = 1;
  localparam int ST_BATT_A    = 0;

  // ----------------------------------------------------------------
  // power control fields
  // ----------------------------------------------------------------
  localparam int PWR_CARD_EN = 7;
  localparam int PWR_COMPAT  = 6;
  localparam int PWR_AUTO    = 5;
  localparam int PWR_VCC_LO  = 3;
  localparam int PWR_VPP_LO  = 0;

  // ----------------------------------------------------------------
  // interrupt and general control fields
  // ----------------------------------------------------------------
  localparam int IGC_RING_EN = 7;
  localparam int IGC_RESET_N = 6;
  localparam int IGC_IS_IO   = 5;
  localparam int IGC_MGMT_EN = 4;
  localparam int IGC_IRQ_LO  = 0;

  // ----------------------------------------------------------------
  // status change flags and irq config fields
  // ----------------------------------------------------------------
  localparam int CSC_DETECT    = 3;
  localparam int CSC_READY     = 2;
  localparam int CSC_BATT_WARN = 1;
  localparam int CSC_BATT_DEAD = 0;
  localparam int CFG_IRQ_LO    = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic vpp_valid_n;
    logic card_ready_irq;
    logic card_write_protect_io16;
    logic card_detect_a_n;
    logic card_detect_b_n;
    logic battery_detect_a_stschange;
    logic battery_detect_b_speaker;
  } card_pins_t;

  typedef struct packed {
    logic       cs;
    logic       sel_data;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic       card_output_enable;
    logic       auto_power;
    logic [1:0] vcc_power;
    logic [1:0] vpp_power;
    logic       card_reset_n;
    logic       ring_enable;
    logic       card_is_io;
    logic [3:0] card_irq_sel;
    logic [3:0] mgmt_irq_sel;
    logic [7:0] window_enable;
    logic       mgmt_irq_req;
  } socket_ctrl_t;

endpackage

/* File: rtl/socket_regs.sv */
// Purpose: writable per-socket registers of one card socket
// Assumes: wr_en is already qualified by device, socket and clock enable
// Notes:   read-only registers are handled by the top

`timescale 1ns/1ps

module socket_regs
  import socket_adapter_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [5:0] reg_sel,
  input  wire logic [7:0] wdata,
  output logic [7:0]      power_ctrl,
  output logic [7:0]      int_gen_ctrl,
  output logic [7:0]      irq_config,
  output logic [7:0]      map_enable
);

  logic [7:0] next_power_ctrl;
  logic [7:0] next_int_gen_ctrl;
  logic [7:0] next_irq_config;
  logic [7:0] next_map_enable;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  always_comb begin
    next_power_ctrl   = power_ctrl;
    next_int_gen_ctrl = int_gen_ctrl;
    next_irq_config   = irq_config;
    next_map_enable   = map_enable;
    if (wr_en) begin
      unique case (reg_sel)
        REG_SOCKET_POWER_CONTROL:  next_power_ctrl   = wdata; // RULE_10
        REG_INTERRUPT_GEN_CONTROL: next_int_gen_ctrl = wdata; // RULE_11
        REG_CHANGE_IRQ_CONFIG:     next_irq_config   = wdata; // RULE_13
        REG_WINDOW_MAP_ENABLE:     next_map_enable   = wdata; // RULE_14
        default: ; // read-only and unmapped indices drop the write
      endcase
    end
  end

  // registers, all clear at reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_ctrl   <= SOCKET_REG_RESET;
      int_gen_ctrl <= SOCKET_REG_RESET;
      irq_config   <= SOCKET_REG_RESET;
      map_enable   <= SOCKET_REG_RESET;
    end else begin
      power_ctrl   <= next_power_ctrl;
      int_gen_ctrl <= next_int_gen_ctrl;
      irq_config   <= next_irq_config;
      map_enable   <= next_map_enable;
    end
  end

endmodule

/* File: rtl/status_change_tracker.sv */
// Purpose: latch card pin changes of one socket as sticky change flags
// Assumes: pins synchronous to clk_sys, ce freezes the tracker
// Notes:   a change in the clearing cycle survives the clear

`timescale 1ns/1ps

module status_change_tracker
  import socket_adapter_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  card_pins_t      pins,
  input  wire logic [3:0] enables,
  input  wire logic       card_is_io,
  input  wire logic       clear,
  output logic [3:0]      flags
);

  card_pins_t prev_pins;
  card_pins_t next_prev_pins;
  logic       primed;
  logic       next_primed;
  logic [3:0] next_flags;
  logic [3:0] set_evt;

  // ----------------------------------------------------------------
  // change detection
  // ----------------------------------------------------------------
  // primed masks the first sample so reset never looks like a change
  always_comb begin
    set_evt                = '0;
    set_evt[CSC_DETECT]    = (pins.card_detect_a_n != prev_pins.card_detect_a_n)
                           | (pins.card_detect_b_n != prev_pins.card_detect_b_n);
    // in I/O mode the ready pin carries the card interrupt, not ready
    set_evt[CSC_READY]     = !card_is_io
                           && (pins.card_ready_irq != prev_pins.card_ready_irq);
    set_evt[CSC_BATT_WARN] = pins.battery_detect_b_speaker
                           != prev_pins.battery_detect_b_speaker;
    set_evt[CSC_BATT_DEAD] = pins.battery_detect_a_stschange
                           != prev_pins.battery_detect_a_stschange;
    set_evt                = set_evt & enables & {CSC_W{primed}}; // RULE_13
    next_prev_pins         = ce ? pins : prev_pins;
    next_primed            = primed | ce;
    next_flags             = flags;
    if (ce) begin
      next_flags = (flags & ~{CSC_W{clear}}) | set_evt; // RULE_12
    end
  end

  // state registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_pins <= '0;
      primed    <= 1'b0;
      flags     <= CSC_RESET;
    end else begin
      prev_pins <= next_prev_pins;
      primed    <= next_primed;
      flags     <= next_flags;
    end
  end

  a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_12
    ce && clear && (set_evt != 4'h0) |=> (flags & $past(set_evt)) == $past(set_evt))
    else $error("change flag lost to a clear");

endmodule

/* File: rtl/socket_adapter_control_regs.sv */
// Purpose: index/data register bank of a two-socket card host adapter
// Assumes: host strobes and card pins are synchronous to clk_sys
// Notes:   reads answer one cycle after the strobe, from a flop
//          socket_ctrl trails the registers by one enabled edge
//          change flags clear on read; a same-edge event survives
//          foreign-device reads answer 00, its writes are dropped
//
// Behaviour
// RULE_01 - index: device bit7, socket bit6, reg 5:0
// RULE_02 - data port reaches register picked by index
// RULE_03 - revision register: id, two zeros, stepping
// RULE_04 - status bit6 shows card power on
// RULE_05 - status bit7 is inverted vpp-valid pin
// RULE_06 - status bit5 is ready/irq pin level
// RULE_07 - status bit4 is write-protect pin level
// RULE_08 - status bits 3:2 inverted card-detect pins
// RULE_09 - status bits 1:0 battery-detect pin levels
// RULE_10 - power control read/write, clears at reset
// RULE_11 - interrupt/general control fields, clears at reset
// RULE_12 - change register flags four events, upper zero
// RULE_13 - irq config: irq select and event enables
// RULE_14 - mapping enable read/write, clears at reset

`timescale 1ns/1ps

module socket_adapter_control_regs
  import socket_adapter_pkg::*;
#(
  parameter logic [1:0] INTERFACE_ID = 2'h1, // arbitrary value
  parameter logic [3:0] STEPPING_REV = 4'h5, // arbitrary value
  parameter logic       DEVICE_ID    = 1'b0
)(
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  host_req_t                          host_req,
  input  card_pins_t [NUM_SOCKETS-1:0]       card_pins,
  output logic [7:0]                         host_rdata,
  output logic                               host_rvalid,
  output socket_ctrl_t [NUM_SOCKETS-1:0]     socket_ctrl
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]                   index_reg;
  logic [7:0]                   next_index;
  logic [7:0]                   next_rdata;
  logic                         next_rvalid;
  socket_ctrl_t [NUM_SOCKETS-1:0] next_ctrl;
  logic [7:0]                   pwr [NUM_SOCKETS];
  logic [7:0]                   igc [NUM_SOCKETS];
  logic [7:0]                   cfg [NUM_SOCKETS];
  logic [7:0]                   map [NUM_SOCKETS];
  logic [3:0]                   csc [NUM_SOCKETS];
  logic [NUM_SOCKETS-1:0]       power_on;
  logic [NUM_SOCKETS-1:0]       sock_wr;
  logic [NUM_SOCKETS-1:0]       sock_clr;
  logic                         dev_ok;
  logic                         idx_wr;
  logic                         data_rd;
  logic                         data_wr;
  logic                         cur_sock;
  logic [5:0]                   cur_reg;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // live pin view, pins read at the moment of the access
  function automatic logic [7:0] status_byte(card_pins_t p, logic pwr_on);
    logic [7:0] s;
    s              = '0;
    s[ST_VPP_VALID] = ~p.vpp_valid_n;                                     // RULE_05
    s[ST_POWER_ON]  = pwr_on;                                             // RULE_04
    s[ST_READY]     = p.card_ready_irq;                                   // RULE_06
    s[ST_WP]        = p.card_write_protect_io16;                          // RULE_07
    s[ST_DETECT_B]  = ~p.card_detect_b_n;                                 // RULE_08
    s[ST_DETECT_A]  = ~p.card_detect_a_n;                                 // RULE_08
    s[ST_BATT_B]    = p.battery_detect_b_speaker;                         // RULE_09
    s[ST_BATT_A]    = p.battery_detect_a_stschange;                       // RULE_09
    return s;
  endfunction

  function automatic logic [7:0] revision_byte();
    return {INTERFACE_ID, 2'b00, STEPPING_REV}; // RULE_03
  endfunction

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  // a bit 7 that differs from DEVICE_ID means another chip owns the data port
  always_comb begin
    cur_sock = index_reg[IDX_SOCKET_BIT];
    cur_reg  = index_reg[IDX_REG_LO +: IDX_REG_W];
    dev_ok   = index_reg[IDX_DEVICE_BIT] == DEVICE_ID;
    idx_wr   = ce && host_req.cs && !host_req.sel_data && host_req.wr;
    data_rd  = ce && host_req.cs && host_req.sel_data && host_req.rd;
    data_wr  = ce && host_req.cs && host_req.sel_data && host_req.wr && dev_ok; // RULE_02
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      sock_wr[s]  = data_wr && (cur_sock == s[0]);
      sock_clr[s] = data_rd && dev_ok && (cur_sock == s[0])
                  && (cur_reg == REG_CARD_STATUS_CHANGE);
      power_on[s] = |pwr[s][PWR_VCC_LO +: 2];
    end
  end

  // ----------------------------------------------------------------
  // per-socket storage
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_SOCKETS; g++) begin : g_socket
    socket_regs u_regs (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .wr_en        (sock_wr[g]),
      .reg_sel      (cur_reg),
      .wdata        (host_req.wdata),
      .power_ctrl   (pwr[g]),
      .int_gen_ctrl (igc[g]),
      .irq_config   (cfg[g]),
      .map_enable   (map[g])
    );

    status_change_tracker u_track (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .ce         (ce),
      .pins       (card_pins[g]),
      .enables    (cfg[g][CSC_W-1:0]),
      .card_is_io (igc[g][IGC_IS_IO]),
      .clear      (sock_clr[g]),
      .flags      (csc[g])
    );
  end

  // ----------------------------------------------------------------
  // index port and read path
  // ----------------------------------------------------------------
  // index read needs no device match; it is shared by the whole chip
  always_comb begin
    next_index  = idx_wr ? host_req.wdata : index_reg; // RULE_01
    next_rvalid = ce ? (host_req.cs && host_req.rd) : host_rvalid;
    next_rdata  = host_rdata;
    if (ce && host_req.cs && host_req.rd) begin
      if (!host_req.sel_data) begin
        next_rdata = index_reg; // RULE_01
      end else if (!dev_ok) begin
        next_rdata = UNMAPPED_READ;
      end else begin
        unique case (cur_reg) // RULE_02
          REG_CHIP_REVISION_ID:      next_rdata = revision_byte();
          REG_SOCKET_IF_STATUS:      next_rdata = status_byte(card_pins[cur_sock],
                                                              power_on[cur_sock]);
          REG_SOCKET_POWER_CONTROL:  next_rdata = pwr[cur_sock];                  // RULE_10
          REG_INTERRUPT_GEN_CONTROL: next_rdata = igc[cur_sock];                  // RULE_11
          REG_CARD_STATUS_CHANGE:    next_rdata = {4'h0, csc[cur_sock]};          // RULE_12
          REG_CHANGE_IRQ_CONFIG:     next_rdata = cfg[cur_sock];                  // RULE_13
          REG_WINDOW_MAP_ENABLE:     next_rdata = map[cur_sock];                  // RULE_14
          default:                   next_rdata = UNMAPPED_READ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // socket control outputs
  // ----------------------------------------------------------------
  // registered copy keeps every output on a flop, at one cycle of lag
  always_comb begin
    next_ctrl = socket_ctrl;
    if (ce) begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
        next_ctrl[s].card_output_enable = pwr[s][PWR_CARD_EN];   // RULE_10
        next_ctrl[s].auto_power         = pwr[s][PWR_AUTO];
        next_ctrl[s].vcc_power          = pwr[s][PWR_VCC_LO +: 2];
        next_ctrl[s].vpp_power          = pwr[s][PWR_VPP_LO +: 2];
        next_ctrl[s].ring_enable        = igc[s][IGC_RING_EN];   // RULE_11
        next_ctrl[s].card_reset_n       = igc[s][IGC_RESET_N];
        next_ctrl[s].card_is_io         = igc[s][IGC_IS_IO];
        next_ctrl[s].card_irq_sel       = igc[s][IGC_IRQ_LO +: 4];
        next_ctrl[s].mgmt_irq_sel       = cfg[s][CFG_IRQ_LO +: 4]; // RULE_13
        next_ctrl[s].window_enable      = map[s];                // RULE_14
        next_ctrl[s].mgmt_irq_req       = igc[s][IGC_MGMT_EN] && (csc[s] != 4'h0);
      end
    end
  end

  // all state lives here apart from the socket submodules
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      index_reg   <= INDEX_RESET;
      host_rdata  <= 8'h00;
      host_rvalid <= 1'b0;
      socket_ctrl <= '0;
    end else begin
      index_reg   <= next_index;
      host_rdata  <= next_rdata;
      host_rvalid <= next_rvalid;
      socket_ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic rd_hit;
  logic stat_rd;
  assign rd_hit  = data_rd && dev_ok;
  assign stat_rd = rd_hit && (cur_reg == REG_SOCKET_IF_STATUS);

  a_index_write: assert property (idx_wr |=> index_reg == $past(host_req.wdata)) // RULE_01
    else $error("index port did not take the written value");

  a_index_frozen: assert property (!ce |=> $stable(index_reg)) // RULE_01
    else $error("index changed while clock enable was low");

  a_foreign_read: assert property (data_rd && !dev_ok |=> host_rdata == UNMAPPED_READ) // RULE_02
    else $error("read for another device returned data");

  a_revision_read: assert property ( // RULE_03
    rd_hit && cur_reg == REG_CHIP_REVISION_ID |=> host_rvalid && host_rdata == revision_byte())
    else $error("revision register read wrong");

  a_power_on_bit: assert property ( // RULE_04
    stat_rd |=> host_rdata[ST_POWER_ON] == $past(power_on[cur_sock]))
    else $error("power-on status bit wrong");

  a_vpp_inverted: assert property ( // RULE_05
    stat_rd |=> host_rdata[ST_VPP_VALID] == !$past(card_pins[cur_sock].vpp_valid_n))
    else $error("vpp valid bit not inverted pin");

  a_ready_level: assert property ( // RULE_06
    stat_rd |=> host_rdata[ST_READY] == $past(card_pins[cur_sock].card_ready_irq))
    else $error("ready bit differs from pin");

  a_wp_level: assert property ( // RULE_07
    stat_rd |=> host_rdata[ST_WP] == $past(card_pins[cur_sock].card_write_protect_io16))
    else $error("write protect bit differs from pin");

  a_detect_inverted: assert property ( // RULE_08
    stat_rd |=> host_rdata[ST_DETECT_B:ST_DETECT_A]
      == ~{$past(card_pins[cur_sock].card_detect_b_n), $past(card_pins[cur_sock].card_detect_a_n)})
    else $error("card detect bits not inverted pins");

  a_battery_levels: assert property ( // RULE_09
    stat_rd |=> host_rdata[ST_BATT_B:ST_BATT_A]
      == {$past(card_pins[cur_sock].battery_detect_b_speaker),
          $past(card_pins[cur_sock].battery_detect_a_stschange)})
    else $error("battery detect bits differ from pins");

  a_power_to_pin: assert property ( // RULE_10
    data_wr && cur_sock == 1'b0 && cur_reg == REG_SOCKET_POWER_CONTROL ##1 ce
      |=> socket_ctrl[0].card_output_enable == $past(host_req.wdata[PWR_CARD_EN], 2))
    else $error("card output enable did not follow the write");

  a_change_upper: assert property ( // RULE_12
    rd_hit && cur_reg == REG_CARD_STATUS_CHANGE |=> host_rdata[7:4] == 4'h0)
    else $error("status change upper bits not zero");

  // writes aimed at another chip must leave this one untouched
  a_foreign_write: assert property ( // RULE_02
    ce && host_req.cs && host_req.sel_data && host_req.wr && !dev_ok
      |=> $stable(pwr[0]) && $stable(map[0]))
    else $error("foreign write changed a register");

  // one valid pulse per taken read, never a stray one
  a_rvalid_pulse: assert property ( // RULE_02
    ce && !(host_req.cs && host_req.rd) |=> !host_rvalid)
    else $error("read valid without a taken read");

  // enables count at the edge that lands the event
  a_change_gated: assert property ( // RULE_13
    (csc[0] & ~$past(csc[0]) & ~$past(cfg[0][CSC_W-1:0])) == 4'h0)
    else $error("change flag set with its enable off");

  // card reset pin trails its control bit by one enabled edge
  a_igc_to_pins: assert property ( // RULE_11
    ce |=> socket_ctrl[1].card_reset_n == $past(igc[1][IGC_RESET_N]))
    else $error("card reset output does not follow the register");

  // window enables reach the mapping logic unchanged
  a_map_to_pins: assert property ( // RULE_14
    ce |=> socket_ctrl[0].window_enable == $past(map[0]))
    else $error("window enables do not follow the register");

  // a low clock enable freezes every host-visible output
  a_outputs_frozen: assert property ( // RULE_02
    !ce |=> $stable(socket_ctrl) && $stable(host_rvalid) && $stable(host_rdata))
    else $error("output moved while clock enable was low");

  // main scenarios the bench is meant to reach
  c_ce_freeze:   cover property (!ce && host_req.cs);
  c_status_read: cover property (stat_rd ##1 host_rvalid);
  c_change_seen: cover property (rd_hit && cur_reg == REG_CARD_STATUS_CHANGE && csc[0] != 4'h0);
  c_map_write:   cover property (data_wr && cur_reg == REG_WINDOW_MAP_ENABLE);
  c_socket1_wr:  cover property (data_wr && cur_sock);

endmodule

/* File: testbench/card_socket_model.sv */
// Purpose: card pin levels seen by one adapter socket
// Assumes: levels change only at the falling clock edge
// Notes:   plain levels, no card timing

`timescale 1ns/1ps

module card_socket_model
  import socket_adapter_pkg::*;
(
  input  wire logic [6:0] pin_levels,
  output card_pins_t      pins
);
  // the card holds its pins as levels; the adapter samples them each edge
  assign pins = pin_levels;
endmodule

/* File: testbench/socket_adapter_control_regs_bench.sv */
// Purpose: self-checking bench of the socket adapter register bank
// Assumes: ce high apart from one freeze test, pins from socket models
// Notes:   inputs move at the falling edge, results are checked mid-cycle

`timescale 1ns/1ps

module socket_adapter_control_regs_bench
  import socket_adapter_pkg::*;
;
  localparam logic [1:0] IF_ID = 2'h1; // arbitrary value
  localparam logic [3:0] STEP  = 4'h5; // arbitrary value
  logic                           clk_sys;
  logic                           rst_n;
  logic                           ce;
  logic                           host_rvalid;
  logic [7:0]                     host_rdata;
  host_req_t                      host_req;
  logic [6:0]                     pin_levels [NUM_SOCKETS];
  card_pins_t [NUM_SOCKETS-1:0]   card_pins;
  socket_ctrl_t [NUM_SOCKETS-1:0] socket_ctrl;
  int                             n_errors;
  int                             n_compared;
  int                             cycles;

  socket_adapter_control_regs #(
    .INTERFACE_ID(IF_ID),
    .STEPPING_REV(STEP),
    .DEVICE_ID   (1'b0)
  ) i_socket_adapter_control_regs (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .ce         (ce),
    .host_req   (host_req),
    .card_pins  (card_pins),
    .host_rdata (host_rdata),
    .host_rvalid(host_rvalid),
    .socket_ctrl(socket_ctrl)
  );

  for (genvar s = 0; s < NUM_SOCKETS; s++) begin : g_sock
    card_socket_model i_card_socket_model (
      .pin_levels(pin_levels[s]),
      .pins      (card_pins[s])
    );
  end

  // ----------------------------------------------------------------
  // clock, hang guard and host access tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // the tests need about 250 cycles; a stuck run is cut off well after
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // one host cycle; the idle cycle after it keeps strobes from merging
  task automatic acc(input logic d, input logic w, input logic [7:0] v);
    @(negedge clk_sys);
    host_req = '{cs: 1'b1, sel_data: d, rd: ~w, wr: w, wdata: v};
    @(negedge clk_sys);
    host_req = '0;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // answer must be valid in the cycle right after the taking edge
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'b0, 1'b1, idx);
    acc(1'b1, 1'b0, 8'h00);
    chk({host_rvalid, host_rdata}, {1'b1, exp});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    acc(1'b0, 1'b1, idx);
    acc(1'b1, 1'b1, v);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [6:0] p;
    socket_ctrl_t c;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    host_req = '0;
    pin_levels[0] = 7'h55;
    pin_levels[1] = 7'h2A;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    for (int r = 2; r < 7; r++) begin
      rd({2'b00, 6'(r)}, 8'h00);
      rd({2'b01, 6'(r)}, 8'h00);
    end
    acc(1'b0, 1'b1, 8'hC7);
    acc(1'b0, 1'b0, 8'h00);
    chk({host_rvalid, host_rdata}, 9'h1C7);
    $display("test reset done");
    wr(8'h00, 8'hFF);
    rd(8'h00, {IF_ID, 2'b00, STEP});
    rd(8'h40, {IF_ID, 2'b00, STEP});
    $display("test revision done");
    // write every socket register but the change flags first, so a socket mix-up shows on read
    for (int k = 0; k < 2; k++) begin
      for (int s = 0; s < 2; s++) begin
        for (int r = 1; r < 7; r++) begin
          v = 8'hA5 ^ 8'(r * 16 + s);
          c = socket_ctrl[s];
          if (k == 0 && r != 4) wr({1'b0, s[0], 6'(r)}, v);
          if (k == 1 && r > 1) rd({1'b0, s[0], 6'(r)}, (r == 4) ? 8'h00 : v);
          if (k == 1 && r == 6) chk({1'b1, socket_ctrl[s].window_enable}, {1'b1, v});
          if (k == 1 && r == 2) chk({3'h7, c.card_output_enable, c.auto_power, c.vcc_power,
                                     c.vpp_power}, {3'h7, v[7], v[5:3], v[1:0]});
          if (k == 1 && r == 3) chk({c.ring_enable, c.card_reset_n, c.card_is_io, 2'b00,
                                     c.card_irq_sel}, {v[7:5], 2'b00, v[3:0]});
          if (k == 1 && r == 5) chk({5'h00, c.mgmt_irq_sel}, {5'h00, v[7:4]});
        end
      end
    end
    $display("test read write done");
    wr(8'h02, 8'h18);
    wr(8'h42, 8'h00);
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 2; s++) begin
        p = pin_levels[s];
        rd({1'b0, s[0], 6'h01}, {~p[6], s == 0, p[5], p[4], ~p[2], ~p[3], p[0], p[1]});
        pin_levels[s] = pin_levels[s] + 7'h13;
      end
    end
    $display("test status done");
    wr(8'h05, 8'h0F);
    wr(8'h45, 8'h00);
    rd(8'h05, 8'h0F);
    acc(1'b0, 1'b1, 8'h04);
    acc(1'b1, 1'b0, 8'h00);
    acc(1'b0, 1'b1, 8'h44);
    acc(1'b1, 1'b0, 8'h00);
    pin_levels[0] = ~pin_levels[0];
    pin_levels[1] = ~pin_levels[1];
    rd(8'h04, 8'h0F);
    rd(8'h04, 8'h00);
    rd(8'h44, 8'h00);
    $display("test change flags done");
    wr(8'h86, 8'h3C);
    rd(8'h86, 8'h00);
    rd(8'h06, 8'hC5);
    rd(8'h07, 8'h00);
    $display("test foreign and unmapped done");
    // an index write while frozen must not land
    ce = 1'b0;
    acc(1'b0, 1'b1, 8'h3F);
    ce = 1'b1;
    acc(1'b0, 1'b0, 8'h00);
    chk({host_rvalid, host_rdata}, 9'h107);
    $display("test clock enable done");
    tally_and_finish();
  end
endmodule
